// File: core/ccm_defs.svh
// Register offsets, field positions and reset values for the clock output and monitor block
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

`define CCM_ADDR_W 4
`define CCM_OFS_CONFIG 4'h0
`define CCM_OFS_CONTROL 4'h4
`define CCM_OFS_STATUS 4'h8
`define CCM_OFS_MASK 4'hC

`define CCM_CFG_SEL_LSB 0
`define CCM_CFG_SEL_MSB 3
`define CCM_CFG_WIDE_BIT 4
`define CCM_CFG_RESET 32'h0000_0000

`define CCM_CTL_XTAL_EN_BIT 0
`define CCM_CTL_MON_EN_BIT 1
`define CCM_CTL_PLL_EN_BIT 2
`define CCM_CTL_SYS_XTAL_BIT 3
`define CCM_CTL_PLL_XTAL_BIT 4
`define CCM_CTL_RESET 32'h0000_0000

`define CCM_STS_FAULT_BIT 0
`define CCM_STS_W 1
`define CCM_STS_RESET 1'h0

`endif

// File: core/ccm_pkg.sv
// Types shared by the clock output and monitor block
package ccm_pkg;
    typedef enum logic [1:0] {
        CCM_MON_IDLE,
        CCM_MON_WATCH,
        CCM_MON_FAILED
    } ccm_mon_state_e;
endpackage

// File: core/ccm_clock_output_monitor.sv
// Clock output selector and crystal clock monitor with Wishbone registers
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`include "ccm_defs.svh"

// Summary of operation
// - In narrow mode codes with top bit 0 give no output; 100 system, 101 RC 8 MHz, 110 crystal, 111 main PLL half.
// - In wide mode codes 00xx give nothing, 01xx as narrow, 1000 second PLL, 1001 third PLL half, 1010 external one, 1011 third PLL.
// - The crystal is supervised only while the monitor enable bit is set.
// - A detected crystal failure switches the crystal oscillator off.
// - A failure sets the clock-blocked fault flag and produces a fault event.
// - The fault event drives the non-maskable interrupt, not the maskable one.
// - If the crystal was the system clock source, the system clock falls back to the RC 8 MHz oscillator.
// - If the crystal fed the PLL, the PLL is switched off on failure.
module ccm_clock_output_monitor #(
    parameter int MISS_LIMIT = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`CCM_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic system_clock_i,
    input wire logic internal_rc_8mhz_clock_i,
    input wire logic high_speed_crystal_clock_i,
    input wire logic main_pll_clock_i,
    input wire logic second_pll_clock_i,
    input wire logic third_pll_clock_i,
    input wire logic external_input_one_i,
    input wire logic pin_alt_function_i,
    output logic clock_output_o,
    output logic clock_output_oe_o,
    output logic high_speed_crystal_oscillator_en_o,
    output logic pll_en_o,
    output logic system_clock_from_crystal_o,
    output logic nmi_o,
    output logic irq_o
);
    localparam int MISS_W = $clog2(MISS_LIMIT + 1);

    logic [31:0] cfg_reg;
    logic [31:0] ctl_reg;
    logic [`CCM_STS_W-1:0] sts_reg;
    logic [`CCM_STS_W-1:0] mask_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    ccm_pkg::ccm_mon_state_e mon_state_reg;
    logic [MISS_W-1:0] miss_reg;
    logic sys_sync;
    logic rc_sync;
    logic xtal_sync;
    logic main_pll_sync;
    logic second_pll_sync;
    logic third_pll_sync;
    logic ext_one_sync;
    logic xtal_change;
    logic main_pll_rise;
    logic third_pll_rise;
    logic out_en;
    logic clk_out_reg;
    logic clk_out_oe_reg;
    logic pll_half_reg;
    logic pll3_half_reg;
    logic [3:0] sel;
    logic wide;
    logic mux_out;
    logic fail_evt;
    logic wr;
    logic rd;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;
    assign sel = cfg_reg[`CCM_CFG_SEL_MSB:`CCM_CFG_SEL_LSB];
    assign wide = cfg_reg[`CCM_CFG_WIDE_BIT];

    // One-wait-state ack, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end
    assign wb_ack_o = ack_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= `CCM_CFG_RESET;
        end else if (wr && wb_adr_i == `CCM_OFS_CONFIG && wb_sel_i[0]) begin
            cfg_reg <= {27'h0, wb_dat_i[4:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= `CCM_CTL_RESET;
        end else begin
            if (wr && wb_adr_i == `CCM_OFS_CONTROL && wb_sel_i[0]) begin
                ctl_reg <= {27'h0, wb_dat_i[4:0]};
            end
            if (fail_evt) begin
                ctl_reg[`CCM_CTL_XTAL_EN_BIT] <= 1'b0;
                if (ctl_reg[`CCM_CTL_SYS_XTAL_BIT]) begin
                    ctl_reg[`CCM_CTL_SYS_XTAL_BIT] <= 1'b0;
                end
                if (ctl_reg[`CCM_CTL_PLL_XTAL_BIT]) begin
                    ctl_reg[`CCM_CTL_PLL_EN_BIT] <= 1'b0;
                end
            end
        end
    end

    // Fault flag: a new failure wins over a write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_reg <= `CCM_STS_RESET;
        end else if (fail_evt) begin
            sts_reg[`CCM_STS_FAULT_BIT] <= 1'b1;
        end else if (wr && wb_adr_i == `CCM_OFS_STATUS && wb_sel_i[0]) begin
            sts_reg <= sts_reg & ~wb_dat_i[`CCM_STS_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= `CCM_STS_RESET;
        end else if (wr && wb_adr_i == `CCM_OFS_MASK && wb_sel_i[0]) begin
            mask_reg <= wb_dat_i[`CCM_STS_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd) begin
            case (wb_adr_i)
                `CCM_OFS_CONFIG: rdata_reg <= cfg_reg;
                `CCM_OFS_CONTROL: rdata_reg <= ctl_reg;
                `CCM_OFS_STATUS: rdata_reg <= {31'h0, sts_reg};
                `CCM_OFS_MASK: rdata_reg <= {31'h0, mask_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = rdata_reg;

    // Every source clock comes from another domain and is synchronised before use
    ccm_sync_edge #(.RESET_VAL(1'b0)) sys_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(system_clock_i),
        .sync_o(sys_sync),
        .rise_o(),
        .change_o()
    );

    ccm_sync_edge #(.RESET_VAL(1'b0)) rc_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(internal_rc_8mhz_clock_i),
        .sync_o(rc_sync),
        .rise_o(),
        .change_o()
    );

    ccm_sync_edge #(.RESET_VAL(1'b0)) xtal_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(high_speed_crystal_clock_i),
        .sync_o(xtal_sync),
        .rise_o(),
        .change_o(xtal_change)
    );

    ccm_sync_edge #(.RESET_VAL(1'b0)) main_pll_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(main_pll_clock_i),
        .sync_o(main_pll_sync),
        .rise_o(main_pll_rise),
        .change_o()
    );

    ccm_sync_edge #(.RESET_VAL(1'b0)) second_pll_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(second_pll_clock_i),
        .sync_o(second_pll_sync),
        .rise_o(),
        .change_o()
    );

    ccm_sync_edge #(.RESET_VAL(1'b0)) third_pll_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(third_pll_clock_i),
        .sync_o(third_pll_sync),
        .rise_o(third_pll_rise),
        .change_o()
    );

    ccm_sync_edge #(.RESET_VAL(1'b0)) ext_one_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(external_input_one_i),
        .sync_o(ext_one_sync),
        .rise_o(),
        .change_o()
    );

    // Halved clocks toggle on each rising edge of their source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_half_reg <= 1'b0;
            pll3_half_reg <= 1'b0;
        end else begin
            if (main_pll_rise) begin
                pll_half_reg <= !pll_half_reg;
            end
            if (third_pll_rise) begin
                pll3_half_reg <= !pll3_half_reg;
            end
        end
    end

    // Monitor: failure when no crystal edge arrives for MISS_LIMIT cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mon_state_reg <= ccm_pkg::CCM_MON_IDLE;
            miss_reg <= '0;
        end else begin
            case (mon_state_reg)
                ccm_pkg::CCM_MON_IDLE: begin
                    miss_reg <= '0;
                    if (ctl_reg[`CCM_CTL_MON_EN_BIT]) begin
                        mon_state_reg <= ccm_pkg::CCM_MON_WATCH;
                    end
                end
                ccm_pkg::CCM_MON_WATCH: begin
                    if (!ctl_reg[`CCM_CTL_MON_EN_BIT]) begin
                        mon_state_reg <= ccm_pkg::CCM_MON_IDLE;
                    end else if (xtal_change) begin
                        miss_reg <= '0;
                    end else if (miss_reg == MISS_W'(MISS_LIMIT - 1)) begin
                        mon_state_reg <= ccm_pkg::CCM_MON_FAILED;
                    end else begin
                        miss_reg <= miss_reg + 1'b1;
                    end
                end
                ccm_pkg::CCM_MON_FAILED: begin
                    miss_reg <= '0;
                    if (!ctl_reg[`CCM_CTL_MON_EN_BIT]) begin
                        mon_state_reg <= ccm_pkg::CCM_MON_IDLE;
                    end
                end
                default: mon_state_reg <= ccm_pkg::CCM_MON_IDLE;
            endcase
        end
    end
    assign fail_evt = (mon_state_reg == ccm_pkg::CCM_MON_WATCH)
        && ctl_reg[`CCM_CTL_MON_EN_BIT] && !xtal_change
        && (miss_reg == MISS_W'(MISS_LIMIT - 1));

    // Source selection, narrow mode ignores the top select bit
    always_comb begin
        mux_out = 1'b0;
        if (!wide) begin
            case (sel[2:0])
                3'h4: mux_out = sys_sync;
                3'h5: mux_out = rc_sync;
                3'h6: mux_out = xtal_sync;
                3'h7: mux_out = pll_half_reg;
                default: mux_out = 1'b0;
            endcase
        end else begin
            case (sel)
                4'h4: mux_out = sys_sync;
                4'h5: mux_out = rc_sync;
                4'h6: mux_out = xtal_sync;
                4'h7: mux_out = pll_half_reg;
                4'h8: mux_out = second_pll_sync;
                4'h9: mux_out = pll3_half_reg;
                4'hA: mux_out = ext_one_sync;
                4'hB: mux_out = third_pll_sync;
                default: mux_out = 1'b0;
            endcase
        end
    end

    // Pin drives only in alternate-function mode and with a valid source
    assign out_en = pin_alt_function_i
        && (wide ? (sel[3:2] != 2'b00 && sel <= 4'hB) : sel[2]);
    // Pin and its enable come from flip-flops so the pin never glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_out_oe_reg <= 1'b0;
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_oe_reg <= out_en;
            clk_out_reg <= out_en & mux_out;
        end
    end
    assign clock_output_oe_o = clk_out_oe_reg;
    assign clock_output_o = clk_out_reg;

    assign high_speed_crystal_oscillator_en_o = ctl_reg[`CCM_CTL_XTAL_EN_BIT];
    assign pll_en_o = ctl_reg[`CCM_CTL_PLL_EN_BIT];
    assign system_clock_from_crystal_o = ctl_reg[`CCM_CTL_SYS_XTAL_BIT];
    assign nmi_o = sts_reg[`CCM_STS_FAULT_BIT];
    assign irq_o = |(sts_reg & mask_reg & ~(`CCM_STS_W'(1) << `CCM_STS_FAULT_BIT));
endmodule

// Two-stage synchroniser with a third stage for edge detection
module ccm_sync_edge #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o,
    output logic rise_o,
    output logic change_o
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Only sync_reg reads meta_reg
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
            last_reg <= RESET_VAL;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign sync_o = sync_reg;
    assign rise_o = sync_reg && !last_reg;
    assign change_o = sync_reg != last_reg;
endmodule

// File: verification/ccm_sva.sv
// Port assertions for the clock output and monitor block
`timescale 1ns/100ps
module ccm_sva #(
    parameter int MISS_LIMIT = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic pin_alt_function_i,
    input wire logic clock_output_o,
    input wire logic clock_output_oe_o,
    input wire logic high_speed_crystal_oscillator_en_o,
    input wire logic pll_en_o,
    input wire logic system_clock_from_crystal_o,
    input wire logic nmi_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    property p_rst; disable iff (1'b0) rst_i |=> !nmi_o && !clock_output_oe_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_pin; !pin_alt_function_i [*2] |-> !clock_output_oe_o && !clock_output_o; endproperty
    a_pin: assert property (p_pin) else $error("pin driven");
    property p_irq; nmi_o |-> !irq_o; endproperty
    a_irq: assert property (p_irq) else $error("fault on maskable line");
    property p_xtal; $rose(nmi_o) |-> !high_speed_crystal_oscillator_en_o; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal left on");
    property p_sys; $rose(nmi_o) |-> !system_clock_from_crystal_o; endproperty
    a_sys: assert property (p_sys) else $error("no fallback");
    property p_flt; $fell(high_speed_crystal_oscillator_en_o) && !wb_ack_o |-> ##[0:1] nmi_o;
    endproperty
    a_flt: assert property (p_flt) else $error("fault flag missing");
    property p_pll; $fell(pll_en_o) && !wb_ack_o |-> ##[0:1] nmi_o; endproperty
    a_pll: assert property (p_pll) else $error("pll off without fault");
    c_flt: cover property ($rose(nmi_o));
    c_oe: cover property (clock_output_oe_o);
    c_ack: cover property (wb_ack_o);
endmodule

bind ccm_clock_output_monitor ccm_sva #(.MISS_LIMIT(MISS_LIMIT)) u_sva (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .pin_alt_function_i(pin_alt_function_i),
    .clock_output_o(clock_output_o),
    .clock_output_oe_o(clock_output_oe_o),
    .high_speed_crystal_oscillator_en_o(high_speed_crystal_oscillator_en_o),
    .pll_en_o(pll_en_o),
    .system_clock_from_crystal_o(system_clock_from_crystal_o),
    .nmi_o(nmi_o),
    .irq_o(irq_o)
);

// File: verification/ccm_xtal_model.sv
// Crystal oscillator model that can be made to die
`timescale 1ns/100ps
module ccm_xtal_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic en_i,
    output logic xtal_o
);
    logic [1:0] ph_reg = 2'h0;
    // Oscillates only while powered and alive, else stands still
    always @(posedge clk_i) begin
        if (run_i && en_i) begin
            ph_reg <= ph_reg + 2'h1;
        end
    end
    assign xtal_o = ph_reg[1];
endmodule

// File: verification/tb_ccm_clock_output_monitor.sv
// Self-checking bench for the clock output and monitor block
`timescale 1ns/100ps
module tb_ccm_clock_output_monitor;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [7:0] c = 8'h0;
    logic run = 0, pin_alt_function_i = 1, clock_output_o, clock_output_oe_o, nmi_o, irq_o;
    logic system_clock_i, internal_rc_8mhz_clock_i, high_speed_crystal_clock_i;
    logic main_pll_clock_i, second_pll_clock_i, third_pll_clock_i, external_input_one_i;
    logic high_speed_crystal_oscillator_en_o, pll_en_o, system_clock_from_crystal_o;
    logic [6:0] srcs;
    logic [20:0] sh = 21'h0;
    int err_total = 0, n_tests = 0, t;
    // Row: wide flag, select code, expected source (7 none, 8 halved)
    logic [11:0] rows [22] = '{12'h007, 12'h017, 12'h027, 12'h037, 12'h0C0, 12'h051,
        12'h062, 12'h078, 12'h107, 12'h117, 12'h127, 12'h137, 12'h140, 12'h151, 12'h162,
        12'h178, 12'h184, 12'h198, 12'h1A6, 12'h1B5, 12'h1C7, 12'h1F7};
    logic [4:0] cv [2] = '{5'h1D, 5'h05};
    assign system_clock_i = c[0];
    assign internal_rc_8mhz_clock_i = c[1];
    assign main_pll_clock_i = c[2];
    assign second_pll_clock_i = c[3];
    assign third_pll_clock_i = c[1] ^ c[3];
    assign external_input_one_i = c[0] ^ c[2];
    assign srcs = {external_input_one_i, third_pll_clock_i, second_pll_clock_i,
        main_pll_clock_i, high_speed_crystal_clock_i, internal_rc_8mhz_clock_i, c[0]};
    always @(posedge clk_i) c <= c + 8'h1;
    // Sources as the output shows them, three clocks late through sync and output flops
    always @(posedge clk_i) sh <= {sh[13:0], srcs};
    initial forever #2 clk_i = ~clk_i;
    ccm_xtal_model xm_u (.clk_i(clk_i), .run_i(run), .en_i(high_speed_crystal_oscillator_en_o),
        .xtal_o(high_speed_crystal_clock_i));
    ccm_clock_output_monitor #(.MISS_LIMIT(8)) dut_u (.*);
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, s, x);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            close_out();
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        chk(clock_output_oe_o, 0);
        wb(0, 4'h4, 0);
        chk(q, 0);
        wb(0, 4'h0, 0);
        chk(q, 0);
        wb(1, 4'h6, 32'hFF);
        wb(0, 4'h6, 0);
        chk(q, 0);
        wb(1, 4'hC, 1);
        run <= 1;
        wb(1, 4'h4, 1);
        foreach (rows[i]) begin
            wb(1, 4'h0, {27'h0, rows[i][8], rows[i][7:4]});
            @(posedge clk_i);
            t = 0;
            repeat (16) begin
                @(negedge clk_i);
                if (rows[i][3:0] == 4'h8) t += clock_output_o;
                else chk(clock_output_o, rows[i][3:0] == 4'h7 ? 1'b0 : sh[14 + rows[i][2:0]]);
            end
            if (rows[i][3:0] == 4'h8) chk(t > 0, 1);
            if (rows[i][3:0] != 4'h7) chk(clock_output_oe_o, 1);
            else chk(clock_output_oe_o, 0);
        end
        wb(1, 4'h0, 4);
        pin_alt_function_i <= 0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(clock_output_oe_o, 0);
        @(posedge clk_i);
        pin_alt_function_i <= 1;
        foreach (cv[i]) begin
            run <= 1;
            wb(1, 4'h4, cv[i]);
            repeat (6) @(posedge clk_i);
            wb(1, 4'h4, cv[i] | 5'h02);
            repeat (40) @(posedge clk_i);
            chk(nmi_o, 0);
            run <= 0;
            t = 0;
            while (nmi_o !== 1'b1 && t < 40) begin
                @(posedge clk_i);
                t++;
            end
            @(negedge clk_i);
            chk(nmi_o, 1);
            chk(high_speed_crystal_oscillator_en_o, 0);
            chk(system_clock_from_crystal_o, 0);
            chk(pll_en_o, cv[i][4] ? 1'b0 : cv[i][2]);
            chk(irq_o, 0);
            wb(0, 4'h8, 0);
            chk(q, 1);
            wb(1, 4'h4, 0);
            wb(1, 4'h8, 1);
            wb(0, 4'h8, 0);
            chk(q, 0);
        end
        wb(1, 4'h4, 1);
        repeat (40) @(posedge clk_i);
        chk(nmi_o, 0);
        wb(1, 4'h0, 32'h14);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 4'h0, 0);
        chk(q, 0);
        chk(clock_output_oe_o, 0);
        close_out();
    end
endmodule
